// [ess_store_seq.sv]
// EEPROM storage sequencer for three sequence entries
// Assumes a same-clock register map with combinational read data and
// an EEPROM link controller that takes bytes by valid and ready
`timescale 1ns/1ps
`include "ess_cfg.svh"
module ess_store_seq #(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register map read port
  output logic [15:0] map_addr,
  input wire logic [7:0] map_rdata,
  // EEPROM byte write port
  output logic ee_valid,
  input wire logic ee_ready,
  output logic [PTR_W-1:0] ee_addr,
  output logic [7:0] ee_data,
  // Status
  output logic busy,
  output ess_pkg::ess_state_type state
);
  import ess_pkg::*;

  // ============================================================
  // Elaboration checks
  if (PTR_W < 8 || PTR_W > 16) begin : g_bad_ptr_w
    $error("PTR_W must lie between 8 and 16");
  end

  // ============================================================
  // Bus slave and register carrier
  ess_reg_if rif();

  ess_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.bus)
  );

  // ============================================================
  // Sequence entries
  logic [7:0] instr_w [`ESS_ENTRIES];
  logic [15:0] addr_w [`ESS_ENTRIES];
  logic [`ESS_ENTRIES-1:0] ent_wr_hit;
  logic [`ESS_ENTRIES-1:0] ent_rd_hit;
  logic [7:0] ent_rd_byte [`ESS_ENTRIES];

  // Entry writes use byte lane zero only
  wire ent_wr = rif.wr_en && rif.wstrb[0];

  // First analog loop and its output drivers
  ess_seq_entry #(
    .INSTR_IDX(`ESS_IDX_E0_INSTR),
    .A_IDX(`ESS_IDX_E0_ADDR_A),
    .B_IDX(`ESS_IDX_E0_ADDR_B),
    .INSTR_RST(`ESS_E0_INSTR_RST), // [R5]
    .ADDR_RST(`ESS_E0_ADDR_RST) // [R5]
  ) u_ent_analog_loop_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(ent_wr),
    .wr_idx(rif.wr_idx),
    .wr_byte(rif.wdata[7:0]),
    .wr_hit(ent_wr_hit[0]),
    .rd_idx(rif.rd_idx),
    .rd_hit(ent_rd_hit[0]),
    .rd_byte(ent_rd_byte[0]),
    .instr(instr_w[0]),
    .start_addr(addr_w[0])
  );

  // First digital loop dividers and bandwidth
  ess_seq_entry #(
    .INSTR_IDX(`ESS_IDX_E1_INSTR),
    .A_IDX(`ESS_IDX_E1_ADDR_A),
    .B_IDX(`ESS_IDX_E1_ADDR_B),
    .INSTR_RST(`ESS_E1_INSTR_RST), // [R6]
    .ADDR_RST(`ESS_E1_ADDR_RST) // [R6]
  ) u_ent_digital_loop_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(ent_wr),
    .wr_idx(rif.wr_idx),
    .wr_byte(rif.wdata[7:0]),
    .wr_hit(ent_wr_hit[1]),
    .rd_idx(rif.rd_idx),
    .rd_hit(ent_rd_hit[1]),
    .rd_byte(ent_rd_byte[1]),
    .instr(instr_w[1]),
    .start_addr(addr_w[1])
  );

  // Second digital loop general settings
  ess_seq_entry #(
    .INSTR_IDX(`ESS_IDX_E2_INSTR),
    .A_IDX(`ESS_IDX_E2_ADDR_A),
    .B_IDX(`ESS_IDX_E2_ADDR_B),
    .INSTR_RST(`ESS_E2_INSTR_RST), // [R7]
    .ADDR_RST(`ESS_E2_ADDR_RST) // [R7]
  ) u_ent_digital_loop_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(ent_wr),
    .wr_idx(rif.wr_idx),
    .wr_byte(rif.wdata[7:0]),
    .wr_hit(ent_wr_hit[2]),
    .rd_idx(rif.rd_idx),
    .rd_hit(ent_rd_hit[2]),
    .rd_byte(ent_rd_byte[2]),
    .instr(instr_w[2]),
    .start_addr(addr_w[2])
  );

  // ============================================================
  // Control, pointer base and status registers
  ess_state_type state_q, state_d;
  logic [PTR_W-1:0] ptr_q, ptr_d, ptr_base_q;
  logic [7:0] ee_data_q, ee_data_d;
  logic [7:0] cnt_q, cnt_d;
  logic [15:0] map_addr_q, map_addr_d;
  logic [1:0] entry_q, entry_d;
  logic [7:0] seq_instr_q, seq_instr_d;
  logic [15:0] seq_addr_q, seq_addr_d;
  logic done_q, done_d;

  // Write decode of own registers
  wire sel_ctrl = (rif.wr_idx == `ESS_IDX_CTRL);
  wire sel_base = (rif.wr_idx == `ESS_IDX_PTR_BASE);
  wire sel_stat = (rif.wr_idx == `ESS_IDX_STATUS);
  wire start_req = rif.wr_en && sel_ctrl && rif.wstrb[0] && rif.wdata[`ESS_CTRL_START];
  wire done_clr = rif.wr_en && sel_stat && rif.wstrb[0] && rif.wdata[`ESS_STAT_DONE];
  assign rif.wr_hit = (|ent_wr_hit) || sel_ctrl || sel_base || sel_stat;

  // Read decode and data selection
  wire rd_ctrl = (rif.rd_idx == `ESS_IDX_CTRL);
  wire rd_base = (rif.rd_idx == `ESS_IDX_PTR_BASE);
  wire rd_stat = (rif.rd_idx == `ESS_IDX_STATUS);
  wire [7:0] ent_byte = ent_rd_byte[0] | ent_rd_byte[1] | ent_rd_byte[2];
  wire [31:0] stat_word = {16'(ptr_q), 14'h0000, done_q, busy};
  assign rif.rd_hit = (|ent_rd_hit) || rd_ctrl || rd_base || rd_stat;
  assign rif.rdata = rd_base ? 32'(ptr_base_q) :
                     rd_stat ? stat_word :
                     (|ent_rd_hit) ? {24'h00_0000, ent_byte} : 32'h0000_0000;

  // Pointer base: low lanes only, ignored while a store runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_base_q <= PTR_W'(`ESS_PTR_BASE_RST);
    end else if (rif.wr_en && sel_base && !busy && (&rif.wstrb[1:0])) begin
      ptr_base_q <= rif.wdata[PTR_W-1:0];
    end
  end

  // ============================================================
  // Store sequencer
  assign busy = (state_q != S_IDLE);
  assign state = state_q;
  assign ee_valid = (state_q == S_INSTR) || (state_q == S_ADDR_LO) ||
                    (state_q == S_ADDR_HI) || (state_q == S_COPY);
  assign ee_addr = ptr_q;
  assign ee_data = ee_data_q;
  assign map_addr = map_addr_q;

  wire take = ee_valid && ee_ready;
  wire last_entry = (entry_q == 2'(`ESS_ENTRIES - 1));
  wire [1:0] entry_nx = entry_q + 2'h1;

  // Next state; entry contents are latched so mid-run writes cannot tear it
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    ee_data_d = ee_data_q;
    cnt_d = cnt_q;
    map_addr_d = map_addr_q;
    entry_d = entry_q;
    seq_instr_d = seq_instr_q;
    seq_addr_d = seq_addr_q;
    done_d = done_q;
    if (done_clr) done_d = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_req) begin
          entry_d = 2'h0;
          ptr_d = ptr_base_q;
          seq_instr_d = instr_w[0];
          seq_addr_d = addr_w[0];
          ee_data_d = instr_w[0]; // [R2]
          state_d = S_INSTR;
        end
      end
      S_INSTR: begin
        if (ee_ready) begin
          ptr_d = ptr_q + 1'b1; // [R2]
          ee_data_d = seq_addr_q[7:0]; // [R3]
          state_d = S_ADDR_LO;
        end
      end
      S_ADDR_LO: begin
        if (ee_ready) begin
          ptr_d = ptr_q + 1'b1; // [R3]
          ee_data_d = seq_addr_q[15:8]; // [R3]
          state_d = S_ADDR_HI;
        end
      end
      S_ADDR_HI: begin
        if (ee_ready) begin
          ptr_d = ptr_q + 1'b1; // [R3]
          map_addr_d = seq_addr_q; // [R1]
          cnt_d = seq_instr_q; // [R1] [R8]
          state_d = S_MAP_RD;
        end
      end
      S_MAP_RD: begin
        ee_data_d = map_rdata; // [R4]
        state_d = S_COPY;
      end
      S_COPY: begin
        if (ee_ready) begin
          ptr_d = ptr_q + 1'b1; // [R4]
          if (cnt_q == 8'h00) begin
            state_d = S_NEXT;
          end else begin
            cnt_d = cnt_q - 8'h01; // [R8]
            map_addr_d = map_addr_q + 16'h0001; // [R4]
            state_d = S_MAP_RD;
          end
        end
      end
      S_NEXT: begin
        if (last_entry) begin
          done_d = 1'b1; // Set wins over a clear in the same cycle
          state_d = S_IDLE;
        end else begin
          entry_d = entry_nx;
          seq_instr_d = instr_w[entry_nx];
          seq_addr_d = addr_w[entry_nx];
          ee_data_d = instr_w[entry_nx]; // [R2]
          state_d = S_INSTR;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      ptr_q <= '0;
      ee_data_q <= 8'h00;
      cnt_q <= 8'h00;
      map_addr_q <= 16'h0000;
      entry_q <= 2'h0;
      seq_instr_q <= 8'h00;
      seq_addr_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      ee_data_q <= ee_data_d;
      cnt_q <= cnt_d;
      map_addr_q <= map_addr_d;
      entry_q <= entry_d;
      seq_instr_q <= seq_instr_d;
      seq_addr_q <= seq_addr_d;
      done_q <= done_d;
    end
  end

  // ============================================================
  // Checking helpers: bytes copied and pointer at entry start
  logic [8:0] copied_q;
  logic [PTR_W-1:0] ent_ptr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      copied_q <= 9'h000;
      ent_ptr_q <= '0;
    end else if (state_q == S_INSTR) begin
      copied_q <= 9'h000;
      ent_ptr_q <= ptr_q;
    end else if (state_q == S_COPY && take) begin
      copied_q <= copied_q + 9'h001;
    end
  end

  // ============================================================
  // Assertions
  a_instr_byte_first: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    (state_q == S_INSTR) |-> ee_valid && ee_data == seq_instr_q)
    else $error("instruction byte not offered first");
  a_instr_ptr_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    (state_q == S_INSTR && ee_ready) |=> state_q == S_ADDR_LO && ptr_q == $past(ptr_q) + 1'b1)
    else $error("pointer did not step after instruction byte");
  a_addr_two_bytes: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (state_q == S_ADDR_LO && ee_ready) |=>
      (state_q == S_ADDR_HI && ee_data == seq_addr_q[15:8] && ptr_q == ent_ptr_q + 2'h2))
    else $error("address bytes or pointer wrong");
  a_copy_start_addr: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (state_q == S_ADDR_HI && ee_ready) |=>
      (state_q == S_MAP_RD && map_addr_q == seq_addr_q && cnt_q == seq_instr_q))
    else $error("copy did not start at entry address");
  a_copy_data_path: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (state_q == S_MAP_RD) |=> state_q == S_COPY && ee_data == $past(map_rdata)
      && map_addr_q == $past(map_addr_q))
    else $error("copied byte differs from register map");
  a_copy_length: assert property (@(posedge aclk) disable iff (!aresetn) // [R1] [R8]
    (state_q == S_NEXT) |-> copied_q == {1'b0, seq_instr_q} + 9'h001)
    else $error("copy length is not instruction plus one");
  a_ptr_advance: assert property (@(posedge aclk) disable iff (!aresetn) // [R4] [R8]
    (state_q == S_NEXT) |-> ptr_q == ent_ptr_q + PTR_W'(copied_q) + PTR_W'(3))
    else $error("pointer advance does not match bytes stored");
  a_byte_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (ee_valid && !ee_ready) |=> ee_valid && $stable(ee_data) && $stable(ee_addr))
    else $error("EEPROM byte changed before it was taken");
  a_reset_entry0: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    $rose(aresetn) |-> instr_w[0] == `ESS_E0_INSTR_RST && addr_w[0] == `ESS_E0_ADDR_RST)
    else $error("first entry reset value wrong");
  a_reset_entry1: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    $rose(aresetn) |-> instr_w[1] == `ESS_E1_INSTR_RST && addr_w[1] == `ESS_E1_ADDR_RST)
    else $error("second entry reset value wrong");
  a_reset_entry2: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    $rose(aresetn) |-> instr_w[2] == `ESS_E2_INSTR_RST && addr_w[2] == `ESS_E2_ADDR_RST)
    else $error("third entry reset value wrong");

endmodule : ess_store_seq

// [ess_cfg.svh]
// Constants of the EEPROM storage sequence block: indexes, resets, fields
// Assumes inclusion by bare name from the package and the design modules
// Notes on behaviour
// [R1] An instruction byte of value N makes the controller copy N+1 bytes from the address after it.
// [R2] At each entry the instruction byte goes to the EEPROM first and the pointer steps by one.
// [R3] The two address bytes that follow go to the EEPROM next and the pointer steps by two.
// [R4] Register-map bytes from that address are then copied and the pointer steps once per byte.
// [R5] The entry at index 0x0E34 resets to instruction 0x0E with start address 0x0530.
// [R6] The entry at index 0x0E37 resets to instruction 0x33 with start address 0x0540.
// [R7] The entry at index 0x0E3A resets to instruction 0x1E with start address 0x0600.
// [R8] The copy length and pointer advance always follow the instruction value plus one.
`ifndef ESS_CFG_SVH
`define ESS_CFG_SVH
// ============================================================
// Register indexes; the byte address is four times the index
`define ESS_IDX_E0_INSTR 14'h0E34
`define ESS_IDX_E0_ADDR_A 14'h0E35
`define ESS_IDX_E0_ADDR_B 14'h0E36
`define ESS_IDX_E1_INSTR 14'h0E37
`define ESS_IDX_E1_ADDR_A 14'h0E38
`define ESS_IDX_E1_ADDR_B 14'h0E39
`define ESS_IDX_E2_INSTR 14'h0E3A
`define ESS_IDX_E2_ADDR_A 14'h0E3B
`define ESS_IDX_E2_ADDR_B 14'h0E3C
`define ESS_IDX_CTRL 14'h0F00
`define ESS_IDX_PTR_BASE 14'h0F01
`define ESS_IDX_STATUS 14'h0F02
// ============================================================
// Reset values
`define ESS_E0_INSTR_RST 8'h0E
`define ESS_E0_ADDR_RST 16'h0530
`define ESS_E1_INSTR_RST 8'h33
`define ESS_E1_ADDR_RST 16'h0540
`define ESS_E2_INSTR_RST 8'h1E
`define ESS_E2_ADDR_RST 16'h0600
`define ESS_PTR_BASE_RST 16'h0000
// ============================================================
// Field positions and bus answers
`define ESS_CTRL_START 0
`define ESS_STAT_BUSY 0
`define ESS_STAT_DONE 1
`define ESS_STAT_PTR_LSB 16
`define ESS_RESP_OKAY 2'h0
`define ESS_RESP_SLVERR 2'h2
`define ESS_ENTRIES 3
`endif

// [ess_pkg.sv]
// Types of the EEPROM storage sequence block
// Assumes ess_cfg.svh on the include path
`include "ess_cfg.svh"
package ess_pkg;
  // Sequencer states, Gray coded along the store path
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_INSTR = 3'b001,
    S_ADDR_LO = 3'b011,
    S_ADDR_HI = 3'b010,
    S_MAP_RD = 3'b110,
    S_COPY = 3'b111,
    S_NEXT = 3'b101
  } ess_state_type;
endpackage : ess_pkg

// [ess_reg_if.sv]
// Internal register access carrier between bus slave and register file
// Assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface ess_reg_if;
  logic wr_en;
  logic [13:0] wr_idx;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_hit;
  logic [13:0] rd_idx;
  logic [31:0] rdata;
  logic rd_hit;
  // Bus slave side
  modport bus (output wr_en, wr_idx, wdata, wstrb, rd_idx, input wr_hit, rdata, rd_hit);
  // Register file side
  modport regs (input wr_en, wr_idx, wdata, wstrb, rd_idx, output wr_hit, rdata, rd_hit);
endinterface : ess_reg_if

// [ess_seq_entry.sv]
// One storage sequence entry: instruction byte and two address bytes
// Assumes byte lane gating and write strobes come from the register file
`timescale 1ns/1ps
module ess_seq_entry #(
  parameter logic [13:0] INSTR_IDX = 14'h0000,
  parameter logic [13:0] A_IDX = 14'h0001,
  parameter logic [13:0] B_IDX = 14'h0002,
  parameter logic [7:0] INSTR_RST = 8'h00,
  parameter logic [15:0] ADDR_RST = 16'h0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic wr_en,
  input wire logic [13:0] wr_idx,
  input wire logic [7:0] wr_byte,
  output logic wr_hit,
  // Read port
  input wire logic [13:0] rd_idx,
  output logic rd_hit,
  output logic [7:0] rd_byte,
  // Entry contents
  output logic [7:0] instr,
  output logic [15:0] start_addr
);
  logic [7:0] instr_q;
  logic [15:0] addr_q;
  // Index decode; byte A is the low address byte
  wire sel_i = (wr_idx == INSTR_IDX);
  wire sel_a = (wr_idx == A_IDX);
  wire sel_b = (wr_idx == B_IDX);
  assign wr_hit = sel_i || sel_a || sel_b;
  assign rd_hit = (rd_idx == INSTR_IDX) || (rd_idx == A_IDX) || (rd_idx == B_IDX);
  assign rd_byte = (rd_idx == INSTR_IDX) ? instr_q :
                   (rd_idx == A_IDX) ? addr_q[7:0] :
                   (rd_idx == B_IDX) ? addr_q[15:8] : 8'h00;
  assign instr = instr_q;
  assign start_addr = addr_q;
  // Entry storage with documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= INSTR_RST;
      addr_q <= ADDR_RST;
    end else if (wr_en) begin
      if (sel_i) instr_q <= wr_byte;
      if (sel_a) addr_q[7:0] <= wr_byte;
      if (sel_b) addr_q[15:8] <= wr_byte;
    end
  end
endmodule : ess_seq_entry

// [ess_axil_slave.sv]
// AXI4-Lite slave front end feeding the register carrier
// Assumes a single clock; register read data settles combinationally
`timescale 1ns/1ps
`include "ess_cfg.svh"
module ess_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register carrier
  ess_reg_if.bus rif
);
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [13:0] awidx_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  // Write fires once both halves are held and no response is pending
  wire do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign rif.wr_en = do_wr;
  assign rif.wr_idx = awidx_q;
  assign rif.wdata = wdata_q;
  assign rif.wstrb = wstrb_q;
  assign rif.rd_idx = s_axi_araddr[15:2];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_have_q <= 1'b1;
      else if (do_wr) aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) w_have_q <= 1'b1;
      else if (do_wr) w_have_q <= 1'b0;
    end
  end
  // Payload holding
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) awidx_q <= s_axi_awaddr[15:2];
    if (s_axi_wvalid && s_axi_wready) wdata_q <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) wstrb_q <= s_axi_wstrb;
  end
  // Responses; unmapped addresses answer SLVERR, reads of them zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ESS_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ESS_RESP_OKAY;
    end else begin
      if (do_wr) bvalid_q <= 1'b1;
      else if (s_axi_bready) bvalid_q <= 1'b0;
      if (do_wr) bresp_q <= rif.wr_hit ? `ESS_RESP_OKAY : `ESS_RESP_SLVERR;
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rif.rd_hit ? rif.rdata : 32'h0000_0000;
        rresp_q <= rif.rd_hit ? `ESS_RESP_OKAY : `ESS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : ess_axil_slave

// [ess_ee_model.sv]
// Partner model: external EEPROM taking bytes by valid and ready
// Assumes the sequencer holds each byte until ready on the shared clock
`timescale 1ns/1ps
module ess_ee_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Byte port
  input wire logic ee_valid,
  input wire logic [15:0] ee_addr,
  input wire logic [7:0] ee_data,
  output logic ee_ready,
  // Pace select
  input wire logic slow
);
  logic [7:0] mem [0:255];
  logic [1:0] pace_q;
  int wr_cnt;
  // Slow mode takes one byte in four cycles
  assign ee_ready = !slow || (pace_q == 2'h3);
  // Keep accepted bytes and count them
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pace_q <= 2'h0;
    else
      pace_q <= pace_q + 2'h1;
    if (ee_valid && ee_ready) begin
      mem[ee_addr[7:0]] <= ee_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : ess_ee_model

// [testbench.sv]
// Testbench of the storage sequencer: AXI4-Lite tasks and store runs
// Assumes the EEPROM partner model and a combinational register map
`timescale 1ns/1ps
module testbench;
  import ess_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ee_valid, ee_ready, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] map_addr, ee_addr;
  logic [7:0] map_rdata, ee_data;
  ess_state_type state;
  int err_count = 0, checked = 0;
  logic [7:0] exp_ins [3] = '{8'h0E, 8'h33, 8'h1E};
  logic [15:0] exp_sa [3] = '{16'h0530, 16'h0540, 16'h0600};
  // ============================================================
  // Clock, register map contents, instances
  always #20 aclk = ~aclk;
  function automatic logic [7:0] map_fn(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction : map_fn
  assign map_rdata = map_fn(map_addr);
  ess_store_seq #(.PTR_W(16)) i_ess_store_seq (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .map_addr,
    .map_rdata, .ee_valid, .ee_ready, .ee_addr, .ee_data, .busy, .state);
  ess_ee_model i_ess_ee_model (.aclk, .aresetn, .ee_valid, .ee_addr, .ee_data, .ee_ready, .slow);
  // ============================================================
  // Verdict, comparison and bus tasks
  task complete_run;
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task hang;
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    complete_run();
  endtask : hang
  // Handshakes are judged at the falling edge, where inputs are settled
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int n;
    n = 0;
    tr = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask : axi_rd
  // Set the pointer base, start, wait for idle, then check the EEPROM image
  task automatic run_store(input logic [15:0] base);
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] p;
    int n0, n;
    axi_wr(16'h3C04, 32'(base), 4'h3, r);
    n0 = i_ess_ee_model.wr_cnt;
    axi_wr(16'h3C00, 32'h0000_0001, 4'h1, r);
    cmp(32'(r), 32'h0000_0000, "start resp");
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    if (n >= 3000) hang();
    p = base;
    for (int e = 0; e < 3; e++) begin
      cmp(32'(i_ess_ee_model.mem[p[7:0]]), 32'(exp_ins[e]), "instr byte");
      cmp(32'(i_ess_ee_model.mem[p[7:0] + 8'h1]), 32'(exp_sa[e][7:0]), "addr low");
      cmp(32'(i_ess_ee_model.mem[p[7:0] + 8'h2]), 32'(exp_sa[e][15:8]), "addr high");
      p = p + 16'h0003;
      for (int i = 0; i <= int'(exp_ins[e]); i++) begin
        cmp(32'(i_ess_ee_model.mem[p[7:0]]), 32'(map_fn(exp_sa[e] + 16'(i))), "map");
        p = p + 16'h0001;
      end
    end
    cmp(32'(i_ess_ee_model.wr_cnt - n0), 32'(p - base), "byte count");
    // Status shows the final pointer and a sticky done that write-one clears
    axi_rd(16'h3C08, d, r);
    cmp(d, {p, 16'h0002}, "status after store");
    axi_wr(16'h3C08, 32'h0000_0002, 4'h1, r);
    axi_rd(16'h3C08, d, r);
    cmp(d, {p, 16'h0000}, "status after clear");
  endtask : run_store
  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] e;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Entry reset values through the bus
    for (int k = 0; k < 9; k++) begin
      axi_rd(16'h38D0 + 16'(4 * k), d, r);
      e = (k % 3 == 0) ? exp_ins[k / 3] : (k % 3 == 1) ? exp_sa[k / 3][7:0] : exp_sa[k / 3][15:8];
      cmp(d, 32'(e), "entry reset");
    end
    // Unmapped read answers with an error
    axi_rd(16'h0000, d, r);
    cmp(32'(r), 32'h0000_0002, "unmapped resp");
    // Default sequence into a slow EEPROM
    slow <= 1'b1;
    run_store(16'h0000);
    // Shortest entry, new start address, raised base, prompt EEPROM
    exp_ins[0] = 8'h00;
    exp_sa[0] = 16'h1234;
    axi_wr(16'h38D0, 32'h0000_0000, 4'h1, r);
    axi_wr(16'h38D4, 32'h0000_0034, 4'h1, r);
    axi_wr(16'h38D8, 32'h0000_0012, 4'h1, r);
    cmp(32'(r), 32'h0000_0000, "entry write resp");
    slow <= 1'b0;
    run_store(16'h0080);
    complete_run();
  end
endmodule : testbench
